// >>> design/dac_ctrl_regs.sv
`timescale 1ns/1ps
module dac_ctrl_regs #(
	parameter int CAL_CYCLES = dac_pkg::CAL_CYCLES,
	parameter int AVG_LOG = dac_pkg::AVG_LOG
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	// calibration comparator
	input wire logic [23:0] cal_meas,
	// modulator and analog controls
	output logic [23:0] mod_code,
	output logic mod_load,
	output logic fast_settle,
	output logic output_connect,
	output logic hold_connect,
	output logic word_width,
	output logic sleep,
	output logic cal_busy
);
	localparam int SAMPLE_GAP = CAL_CYCLES / (2 << AVG_LOG);

	logic sclk_s, cs_n_s, sdio_s, sclk_d_r;
	logic fall_w, rise_w;

	dac_pkg::serial_state_e st_r;
	logic [2:0] bit_cnt_r;
	logic [1:0] byte_left_r;
	logic [3:0] addr_r, addr_step_w;
	logic dec_r;
	logic [7:0] shift_r, rx_byte_w, tx_r;

	dac_pkg::ctrl_s ctrl_r, ctrl_sh_r, ctrl_sh_nxt, ctrl_new_w;
	logic [23:0] code_r, off_r, gain_r;
	logic [23:0] code_sh_r, off_sh_r, gain_sh_r;
	logic [23:0] code_sh_nxt, off_sh_nxt, gain_sh_nxt;
	logic instr_done_w, wr_byte_w, commit_w, commit_ok_w, code_upd_r;

	logic cal_start_w, cal_busy_w, cal_done_w;
	logic [23:0] cal_off_w, cal_gain_w;

	logic [23:0] sb_w, masked_w, corr_w, step_w;
	logic [47:0] prod_w;
	logic signed [26:0] total_w;

	// link clock is only sampled; the synchroniser resets to idle, sclk low and cs_n high
	pin_sync #(.WIDTH(3), .RESET_VAL(3'b010)) u_sync (
		.clk(clk),
		.rst(rst),
		.pin_in({sclk, cs_n, sdio_in}),
		.pin_out({sclk_s, cs_n_s, sdio_s})
	);

	trim_cal_engine #(.AVG_LOG(AVG_LOG), .SAMPLE_GAP(SAMPLE_GAP)) u_cal (
		.clk(clk),
		.rst(rst),
		.start(cal_start_w),
		.meas(cal_meas),
		.busy(cal_busy_w),
		.done(cal_done_w),
		.offset_result(cal_off_w),
		.gain_result(cal_gain_w)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
		end
	end

	// edges count only while selected
	assign fall_w = sclk_d_r & ~sclk_s & ~cs_n_s;
	assign rise_w = ~sclk_d_r & sclk_s & ~cs_n_s;

	function automatic logic [7:0] rd_byte(input logic [3:0] a, input logic [15:0] c,
		input logic [23:0] d, input logic [23:0] o, input logic [23:0] g);
		case (a)
			dac_pkg::ADDR_CODE_B2: rd_byte = d[23:16];
			dac_pkg::ADDR_CODE_B1: rd_byte = d[15:8];
			dac_pkg::ADDR_CODE_B0: rd_byte = d[7:0];
			dac_pkg::ADDR_CTRL_B1: rd_byte = c[15:8];
			dac_pkg::ADDR_CTRL_B0: rd_byte = c[7:0];
			dac_pkg::ADDR_OFFS_B2: rd_byte = o[23:16];
			dac_pkg::ADDR_OFFS_B1: rd_byte = o[15:8];
			dac_pkg::ADDR_OFFS_B0: rd_byte = o[7:0];
			dac_pkg::ADDR_GAIN_B2: rd_byte = g[23:16];
			dac_pkg::ADDR_GAIN_B1: rd_byte = g[15:8];
			dac_pkg::ADDR_GAIN_B0: rd_byte = g[7:0];
			default: rd_byte = 8'h00;
		endcase
	endfunction

	assign rx_byte_w = ctrl_r.bit_order ? {sdio_s, shift_r[7:1]} : {shift_r[6:0], sdio_s};
	assign addr_step_w = dec_r ? addr_r - 4'h1 : addr_r + 4'h1;
	assign instr_done_w = fall_w && st_r == dac_pkg::ST_INSTR && bit_cnt_r == 3'h7;
	assign wr_byte_w = fall_w && st_r == dac_pkg::ST_WRITE && bit_cnt_r == 3'h7;
	assign commit_w = wr_byte_w && byte_left_r == 2'h0;
	assign commit_ok_w = commit_w && !cal_busy_w && !cal_done_w;
	assign cal_start_w = commit_ok_w && ctrl_new_w.operating_mode_field == dac_pkg::MODE_CAL;

	// serial sequencer: instruction byte, then the counted data bytes
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= dac_pkg::ST_INSTR;
			bit_cnt_r <= 3'h0;
			byte_left_r <= 2'h0;
			addr_r <= 4'h0;
			dec_r <= 1'b0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
		end else if (fall_w) begin
			shift_r <= rx_byte_w;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == 3'h7) begin
				unique case (st_r)
					dac_pkg::ST_INSTR: begin
						addr_r <= rx_byte_w[dac_pkg::INSTR_ADDR_HI:0];
						// count code 11 is taken as three bytes
						byte_left_r <= (rx_byte_w[dac_pkg::INSTR_NB_HI:dac_pkg::INSTR_NB_LO] == 2'h3) ? 2'h2 :
							rx_byte_w[dac_pkg::INSTR_NB_HI:dac_pkg::INSTR_NB_LO];
						// control word writes always ascend
						dec_r <= ctrl_r.byte_direction && (rx_byte_w[dac_pkg::INSTR_RW_BIT] ||
							rx_byte_w[dac_pkg::INSTR_ADDR_HI:1] != dac_pkg::CTRL_ADDR_PAGE);
						st_r <= rx_byte_w[dac_pkg::INSTR_RW_BIT] ? dac_pkg::ST_READ : dac_pkg::ST_WRITE;
						tx_r <= rd_byte(rx_byte_w[dac_pkg::INSTR_ADDR_HI:0], ctrl_r, code_r, off_r, gain_r);
					end
					dac_pkg::ST_WRITE, dac_pkg::ST_READ: begin
						addr_r <= addr_step_w;
						tx_r <= rd_byte(addr_step_w, ctrl_r, code_r, off_r, gain_r);
						byte_left_r <= byte_left_r - 2'h1;
						if (byte_left_r == 2'h0) begin
							st_r <= dac_pkg::ST_INSTR;
						end
					end
				endcase
			end
		end
	end

	// read data leaves on the rising edge, host samples on the falling one
	always_ff @(posedge clk) begin
		if (rst) begin
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
		end else begin
			sdio_oe <= st_r == dac_pkg::ST_READ;
			if (rise_w && st_r == dac_pkg::ST_READ) begin
				sdio_out <= ctrl_r.bit_order ? tx_r[bit_cnt_r] : tx_r[3'h7 - bit_cnt_r];
			end
		end
	end

	// bytes land in shadow copies; nothing takes effect before the last bit
	always_comb begin
		ctrl_sh_nxt = ctrl_sh_r;
		code_sh_nxt = code_sh_r;
		off_sh_nxt = off_sh_r;
		gain_sh_nxt = gain_sh_r;
		if (wr_byte_w) begin
			case (addr_r)
				dac_pkg::ADDR_CODE_B2: code_sh_nxt[23:16] = rx_byte_w;
				dac_pkg::ADDR_CODE_B1: code_sh_nxt[15:8] = rx_byte_w;
				dac_pkg::ADDR_CODE_B0: code_sh_nxt[7:0] = rx_byte_w;
				dac_pkg::ADDR_CTRL_B1: ctrl_sh_nxt[15:8] = rx_byte_w;
				dac_pkg::ADDR_CTRL_B0: ctrl_sh_nxt[7:0] = rx_byte_w;
				dac_pkg::ADDR_OFFS_B2: off_sh_nxt[23:16] = rx_byte_w;
				dac_pkg::ADDR_OFFS_B1: off_sh_nxt[15:8] = rx_byte_w;
				dac_pkg::ADDR_OFFS_B0: off_sh_nxt[7:0] = rx_byte_w;
				dac_pkg::ADDR_GAIN_B2: gain_sh_nxt[23:16] = rx_byte_w;
				dac_pkg::ADDR_GAIN_B1: gain_sh_nxt[15:8] = rx_byte_w;
				dac_pkg::ADDR_GAIN_B0: gain_sh_nxt[7:0] = rx_byte_w;
				default: ;
			endcase
		end
		ctrl_new_w = dac_pkg::ctrl_s'((ctrl_sh_nxt & ~dac_pkg::CTRL_FIXED_MASK) | dac_pkg::CTRL_FIXED_VAL);
		ctrl_new_w.trim_clear = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_sh_r <= dac_pkg::CTRL_RESET;
			code_sh_r <= dac_pkg::CODE_RESET;
			off_sh_r <= dac_pkg::TRIM_RESET;
			gain_sh_r <= dac_pkg::TRIM_RESET;
		end else if (instr_done_w) begin
			ctrl_sh_r <= ctrl_r;
			code_sh_r <= code_r;
			off_sh_r <= off_r;
			gain_sh_r <= gain_r;
		end else begin
			ctrl_sh_r <= ctrl_sh_nxt;
			code_sh_r <= code_sh_nxt;
			off_sh_r <= off_sh_nxt;
			gain_sh_r <= gain_sh_nxt;
		end
	end

	// control word and trims; calibration completion outranks a write
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= dac_pkg::CTRL_RESET;
			off_r <= dac_pkg::TRIM_RESET;
			gain_r <= dac_pkg::TRIM_RESET;
		end else if (cal_done_w) begin
			ctrl_r.operating_mode_field <= dac_pkg::MODE_NORMAL;
			off_r <= cal_off_w;
			gain_r <= cal_gain_w;
		end else if (commit_ok_w) begin
			ctrl_r <= ctrl_new_w;
			if (ctrl_sh_nxt.trim_clear) begin
				off_r <= dac_pkg::TRIM_RESET;
				gain_r <= dac_pkg::TRIM_RESET;
			end else begin
				off_r <= off_sh_nxt;
				gain_r <= gain_sh_nxt;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			code_r <= dac_pkg::CODE_RESET;
			code_upd_r <= 1'b0;
		end else begin
			code_upd_r <= commit_ok_w;
			if (commit_ok_w) begin
				code_r <= ctrl_new_w.input_clear ? dac_pkg::CODE_RESET : code_sh_nxt;
			end
		end
	end

	// correction: straight binary, resolution mask, then linear trims
	always_comb begin
		sb_w = ctrl_r.code_format ? code_r : (code_r ^ dac_pkg::CODE_MID);
		masked_w = sb_w & (ctrl_r.word_width_select ? dac_pkg::MASK20 : dac_pkg::MASK16);
		prod_w = masked_w * gain_r;
		total_w = $signed({3'b000, masked_w}) + $signed({{3{off_r[23]}}, off_r}) +
			$signed({3'b000, prod_w[47:24]});
		if (total_w[26]) begin
			corr_w = 24'h000000;
		end else if (total_w[25:24] != 2'h0) begin
			corr_w = 24'hffffff;
		end else begin
			corr_w = total_w[23:0];
		end
		step_w = (corr_w > mod_code) ? corr_w - mod_code : mod_code - corr_w;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mod_code <= 24'h000000;
			mod_load <= 1'b0;
			fast_settle <= 1'b0;
			output_connect <= 1'b0;
			hold_connect <= 1'b0;
			word_width <= 1'b0;
			sleep <= 1'b1;
			cal_busy <= 1'b0;
		end else begin
			mod_code <= corr_w;
			mod_load <= code_upd_r;
			if (code_upd_r) begin
				fast_settle <= !ctrl_r.fast_settle_off &&
					(ctrl_r.step_size_filter_off || step_w > dac_pkg::STEP_THRESH);
			end
			// sleep, and calibration unless kept connected, isolate the output
			output_connect <= ctrl_r.operating_mode_field != dac_pkg::MODE_SLEEP &&
				!(cal_busy_w && !ctrl_r.output_during_trim);
			hold_connect <= ctrl_r.reference_hold_connect;
			word_width <= ctrl_r.word_width_select;
			sleep <= ctrl_r.operating_mode_field == dac_pkg::MODE_SLEEP;
			cal_busy <= cal_busy_w;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence read_byte_end_s;
		fall_w && st_r == dac_pkg::ST_READ && bit_cnt_r == 3'h7 && byte_left_r != 2'h0;
	endsequence
	sequence cal_finish_s;
		cal_done_w ##1 (ctrl_r.operating_mode_field == dac_pkg::MODE_NORMAL && !cal_busy_w);
	endsequence
	sequence cal_launch_s;
		cal_start_w ##1 cal_busy_w [*2];
	endsequence

	ctrl_adopt_a: assert property (commit_ok_w |=> ctrl_r == $past(ctrl_new_w))
		else $error("control word not adopted after last write bit");
	ctrl_hold_a: assert property (!commit_ok_w && !cal_done_w |=> $stable(ctrl_r))
		else $error("control word changed without a commit");
	fixed_bits_a: assert property ((ctrl_r & dac_pkg::CTRL_FIXED_MASK) == dac_pkg::CTRL_FIXED_VAL)
		else $error("fixed control bits corrupted");
	filter_off_a: assert property (code_upd_r && !ctrl_r.fast_settle_off && ctrl_r.step_size_filter_off
		|=> fast_settle && mod_load)
		else $error("fast settling not forced with filter off");
	fast_off_a: assert property (code_upd_r && ctrl_r.fast_settle_off |=> !fast_settle)
		else $error("fast settling used while disabled");
	trim_isolate_a: assert property (cal_busy_w && !ctrl_r.output_during_trim |=> !output_connect)
		else $error("output connected during isolated calibration");
	hold_cap_a: assert property (##1 hold_connect == $past(ctrl_r.reference_hold_connect))
		else $error("hold capacitor control wrong");
	trim_clear_a: assert property (commit_ok_w && ctrl_sh_nxt.trim_clear
		|=> off_r == dac_pkg::TRIM_RESET && gain_r == dac_pkg::TRIM_RESET && !ctrl_r.trim_clear)
		else $error("trims not cleared");
	width_mask_a: assert property (!ctrl_r.word_width_select |-> masked_w[7:0] == 8'h00)
		else $error("16-bit mode keeps low code bits");
	input_clear_a: assert property (commit_ok_w && ctrl_new_w.input_clear |=> code_r == dac_pkg::CODE_RESET)
		else $error("input code not cleared");
	code_map_a: assert property (code_upd_r && ctrl_r.code_format && off_r == 24'h000000 && gain_r == 24'h000000
		|=> mod_code == ($past(code_r) & $past(masked_w | ~masked_w) &
		($past(ctrl_r.word_width_select) ? dac_pkg::MASK20 : dac_pkg::MASK16)))
		else $error("straight binary code mismatch");
	read_step_a: assert property (read_byte_end_s |=> addr_r == ($past(dec_r) ? $past(addr_r) - 4'h1 :
		$past(addr_r) + 4'h1))
		else $error("read address step wrong");
	cal_launch_a: assert property (cal_start_w |-> cal_launch_s)
		else $error("calibration did not start");
	cal_ignore_a: assert property (cal_busy_w |=> $stable(code_r) && $stable(ctrl_sh_r.operating_mode_field) ||
		!cal_busy_w || $past(instr_done_w) || $past(wr_byte_w))
		else $error("write accepted during calibration");
	cal_return_a: assert property (cal_done_w |-> cal_finish_s)
		else $error("mode did not return to normal");
endmodule

// >>> design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// asynchronous pins and their synchronised copies
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] meta_r;

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (rst) begin
				meta_r[i] <= RESET_VAL[i];
				pin_out[i] <= RESET_VAL[i];
			end else begin
				meta_r[i] <= pin_in[i];
				pin_out[i] <= meta_r[i];
			end
		end
	end
endmodule

// >>> design/trim_cal_engine.sv
`timescale 1ns/1ps
module trim_cal_engine #(
	parameter int AVG_LOG = dac_pkg::AVG_LOG,
	parameter int SAMPLE_GAP = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request and comparator samples
	input wire logic start,
	input wire logic [23:0] meas,
	// results
	output logic busy,
	output logic done,
	output logic [23:0] offset_result,
	output logic [23:0] gain_result
);
	localparam int ACC_W = 24 + AVG_LOG;
	localparam int GAP_W = $clog2(SAMPLE_GAP + 1);
	localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(SAMPLE_GAP - 1);
	localparam logic [AVG_LOG-1:0] CNT_LAST = '1;

	dac_pkg::cal_state_e st_r;
	logic [GAP_W-1:0] gap_r;
	logic [AVG_LOG-1:0] cnt_r;
	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] sum_w;

	assign sum_w = acc_r + {{AVG_LOG{1'b0}}, meas};

	// one sequence: offset phase then gain phase, each averaging 2**AVG_LOG samples
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= dac_pkg::CAL_IDLE;
			gap_r <= '0;
			cnt_r <= '0;
			acc_r <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			offset_result <= dac_pkg::TRIM_RESET;
			gain_result <= dac_pkg::TRIM_RESET;
		end else begin
			done <= 1'b0;
			unique case (st_r)
				dac_pkg::CAL_IDLE: begin
					if (start) begin
						st_r <= dac_pkg::CAL_OFFS;
						busy <= 1'b1;
						gap_r <= '0;
						cnt_r <= '0;
						acc_r <= '0;
					end
				end
				dac_pkg::CAL_OFFS, dac_pkg::CAL_GAIN: begin
					gap_r <= (gap_r == GAP_LAST) ? '0 : gap_r + 1'b1;
					if (gap_r == GAP_LAST) begin
						acc_r <= sum_w;
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == CNT_LAST) begin
							acc_r <= '0;
							if (st_r == dac_pkg::CAL_OFFS) begin
								// averaged, then stored in offset two's complement form
								offset_result <= sum_w[ACC_W-1:AVG_LOG] ^ dac_pkg::CODE_MID;
								st_r <= dac_pkg::CAL_GAIN;
							end else begin
								gain_result <= sum_w[ACC_W-1:AVG_LOG];
								st_r <= dac_pkg::CAL_IDLE;
								busy <= 1'b0;
								done <= 1'b1;
							end
						end
					end
				end
			endcase
		end
	end
endmodule

// >>> include/dac_pkg.sv
package dac_pkg;
	localparam int CLK_HZ = 10_000_000;

	// control word layout, bit 15 down to bit 0
	typedef struct packed {
		logic step_size_filter_off;
		logic output_during_trim;
		logic reference_hold_connect;
		logic [2:0] fixed_hi;
		logic trim_clear;
		logic fixed_lo;
		logic word_width_select;
		logic input_clear;
		logic code_format;
		logic fast_settle_off;
		logic byte_direction;
		logic bit_order;
		logic [1:0] operating_mode_field;
	} ctrl_s;

	localparam logic [15:0] CTRL_RESET = 16'h0802;
	localparam logic [15:0] CTRL_FIXED_MASK = 16'h1d00;
	localparam logic [15:0] CTRL_FIXED_VAL = 16'h0800;

	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_CAL = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;

	// instruction byte fields
	localparam int INSTR_RW_BIT = 7;
	localparam int INSTR_NB_HI = 6;
	localparam int INSTR_NB_LO = 5;
	localparam int INSTR_ADDR_HI = 3;
	localparam logic [2:0] CTRL_ADDR_PAGE = 3'h2;

	localparam logic [3:0] ADDR_CODE_B2 = 4'h0;
	localparam logic [3:0] ADDR_CODE_B1 = 4'h1;
	localparam logic [3:0] ADDR_CODE_B0 = 4'h2;
	localparam logic [3:0] ADDR_CTRL_B1 = 4'h4;
	localparam logic [3:0] ADDR_CTRL_B0 = 4'h5;
	localparam logic [3:0] ADDR_OFFS_B2 = 4'h8;
	localparam logic [3:0] ADDR_OFFS_B1 = 4'h9;
	localparam logic [3:0] ADDR_OFFS_B0 = 4'ha;
	localparam logic [3:0] ADDR_GAIN_B2 = 4'hc;
	localparam logic [3:0] ADDR_GAIN_B1 = 4'hd;
	localparam logic [3:0] ADDR_GAIN_B0 = 4'he;

	localparam logic [23:0] CODE_MID = 24'h800000;
	localparam logic [23:0] MASK16 = 24'hffff00;
	localparam logic [23:0] MASK20 = 24'hfffff0;
	localparam logic [23:0] TRIM_RESET = 24'h000000;
	localparam logic [23:0] CODE_RESET = 24'h000000;

	// adaptive filter threshold: 40 mV of a 5000 mV span, in 24-bit code units
	localparam longint STEP_MV = 40;
	localparam longint FULL_SCALE_MV = 5000;
	localparam logic [23:0] STEP_THRESH = 24'((STEP_MV * 64'd16777216) / FULL_SCALE_MV);

	localparam longint CAL_TIME_MS = 300;
	localparam int CAL_CYCLES = int'((CAL_TIME_MS * CLK_HZ) / 1000);
	localparam int AVG_LOG = 4;

	typedef enum logic [2:0] {ST_INSTR = 3'b001, ST_WRITE = 3'b010, ST_READ = 3'b100} serial_state_e;
	typedef enum logic [2:0] {CAL_IDLE = 3'b001, CAL_OFFS = 3'b010, CAL_GAIN = 3'b100} cal_state_e;
endpackage

// >>> verif/dac_ctrl_regs_tb.sv
`timescale 1ns/1ps
module dac_ctrl_regs_tb;
	logic clk = 1'b0;
	logic rst;
	logic sclk, cs_n, sdio_in, sdio_out, sdio_oe;
	logic [23:0] cal_meas, mod_code;
	logic mod_load, fast_settle, output_connect, hold_connect, word_width, sleep, cal_busy;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int loads = 0;
	int n;
	logic [3:0] s;
	logic [7:0] mem [16];
	logic [3:0] bases [3] = '{4'h0, 4'h8, 4'hc};
	logic [15:0] table_w [6] = '{16'h2800, 16'ha820, 16'h28a0, 16'h391c, 16'h2840, 16'h2802};

	dac_ctrl_regs #(.CAL_CYCLES(320), .AVG_LOG(4)) dac_ctrl_regs_i (.clk(clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .cal_meas(cal_meas),
		.mod_code(mod_code), .mod_load(mod_load), .fast_settle(fast_settle), .output_connect(output_connect),
		.hold_connect(hold_connect), .word_width(word_width), .sleep(sleep), .cal_busy(cal_busy));

	serial_host serial_host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe));

	always #50 clk = ~clk;

	always @(negedge clk) begin
		cycles++;
		if (mod_load === 1'b1) loads++;
		if (cycles == 40000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// control writes always ascend, everything else follows the byte direction
	function automatic logic [3:0] step(input logic [3:0] a, input int k, input logic ctl_wr);
		return (mem[5][3] && !ctl_wr) ? a - 4'(k) : a + 4'(k);
	endfunction

	function automatic logic [23:0] expect_code();
		longint sb, v;
		sb = {mem[0], mem[1], mem[2]} ^ (mem[5][5] ? 24'h0 : dac_pkg::CODE_MID);
		sb = sb & (mem[5][7] ? dac_pkg::MASK20 : dac_pkg::MASK16);
		v = sb + longint'($signed({mem[8], mem[9], mem[10]})) + ((sb * {mem[12], mem[13], mem[14]}) >> 24);
		return v < 0 ? 24'h0 : (v > 24'hffffff ? 24'hffffff : v[23:0]);
	endfunction

	task automatic rd(input logic [3:0] a, input int n);
		logic [23:0] got, exp;
		exp = '0;
		for (int k = 0; k < n; k++) exp[23 - 8 * k -: 8] = mem[step(a, k, 1'b0)];
		serial_host_i.xfer(1'b1, n, a, mem[5][2], 24'h0, got);
		check(got, exp);
	endtask

	task automatic wr(input logic [3:0] a, input int n, input logic [23:0] d);
		logic [23:0] unused;
		logic [3:0] t;
		int l0;
		logic dropped;
		dropped = cal_busy === 1'b1;
		l0 = loads;
		serial_host_i.xfer(1'b0, n, a, mem[5][2], d, unused);
		repeat (4) @(negedge clk);
		check(24'(loads - l0), dropped ? 24'h0 : 24'h1);
		if (!dropped) begin
			for (int k = 0; k < n; k++) begin
				t = step(a, k, a == 4'h4 || a == 4'h5);
				if (!(t inside {4'h3, 4'h6, 4'h7, 4'hb, 4'hf})) mem[t] = d[23 - 8 * k -: 8];
			end
			{mem[4], mem[5]} = ({mem[4], mem[5]} & ~dac_pkg::CTRL_FIXED_MASK) | dac_pkg::CTRL_FIXED_VAL;
			if (mem[4][1]) {mem[8], mem[9], mem[10], mem[12], mem[13], mem[14]} = '0;
			mem[4][1] = 1'b0;
			if (mem[5][6]) {mem[0], mem[1], mem[2]} = '0;
		end
	endtask

	task automatic outs();
		check(24'(sleep), 24'(mem[5][1:0] == 2'h2));
		check(24'(hold_connect), 24'(mem[4][5]));
		check(24'(word_width), 24'(mem[5][7]));
		if (mem[5][1:0] == 2'h0) check(mod_code, expect_code());
		if (mem[5][4]) check(24'(fast_settle), 24'h0);
		else if (mem[4][7] && !mem[5][7]) check(24'(fast_settle), 24'h1);
	endtask

	initial begin
		rst = 1'b1;
		cal_meas = 24'h0;
		void'($urandom(32'h0d6c2205));
		foreach (mem[i]) mem[i] = 8'h00;
		{mem[4], mem[5]} = dac_pkg::CTRL_RESET;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		rd(4'h4, 1);
		rd(4'h5, 1);
		outs();
		foreach (table_w[i]) begin
			wr(4'h4, 2, {table_w[i], 8'h00});
			rd(4'h4, 2);
			for (int r = 0; r < 3; r++) begin
				s = mem[5][3] ? bases[r] + 4'h2 : bases[r];
				wr(s, 3, 24'($urandom) >> (r * 3));
				rd(s, 3);
			end
			outs();
		end
		// trims cleared, and the clear bit itself never sticks
		// straight binary with both trims cleared exercises the plain code map
		wr(4'h4, 2, {16'h2a20, 8'h00});
		rd(4'h4, 2);
		rd(4'h8, 3);
		rd(4'hc, 3);
		outs();
		for (int t = 0; t < 2; t++) begin
			cal_meas = 24'($urandom);
			wr(4'h4, 2, {16'h2801 | 16'(t << 14), 8'h00});
			n = 0;
			while (cal_busy !== 1'b1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			check(24'(cal_busy), 24'h1);
			check(24'(output_connect), 24'(t));
			wr(4'h4, 2, {16'h2880, 8'h00});
			n = 0;
			while (cal_busy === 1'b1 && n < 1000) begin
				@(negedge clk);
				n++;
			end
			check(24'(cal_busy), 24'h0);
			mem[5][1:0] = dac_pkg::MODE_NORMAL;
			{mem[8], mem[9], mem[10]} = cal_meas ^ dac_pkg::CODE_MID;
			{mem[12], mem[13], mem[14]} = cal_meas;
			repeat (4) @(negedge clk);
			rd(4'h4, 2);
			rd(4'h8, 3);
			rd(4'hc, 3);
		end
		final_report();
	end
endmodule

// >>> verif/serial_host.sv
`timescale 1ns/1ps
module serial_host (
	// system clock, used only to pace the link
	input wire logic clk,
	// serial link
	output logic sclk,
	output logic cs_n,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe
);
	logic drv;
	logic drv_en;

	// a released line shows the inverse of the last bit, never a stale copy
	assign sdio_in = sdio_oe ? sdio_out : (drv_en ? drv : ~drv);

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		drv = 1'b0;
		drv_en = 1'b0;
	end

	task automatic shift(input logic [7:0] tx, input logic lsb, input logic out_en, output logic [7:0] rx);
		int idx;
		for (int i = 0; i < 8; i++) begin
			idx = lsb ? i : 7 - i;
			drv = tx[idx];
			drv_en = out_en;
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			rx[idx] = sdio_in;
			sclk = 1'b0;
			repeat (4) @(negedge clk);
		end
	endtask

	// one whole transfer; the first data byte after the instruction byte sits in bits 23:16
	task automatic xfer(input logic rd, input int n, input logic [3:0] a, input logic lsb,
		input logic [23:0] wd, output logic [23:0] rq);
		logic [7:0] b;
		rq = '0;
		cs_n = 1'b0;
		repeat (2) @(negedge clk);
		shift({rd, 2'(n - 1), 1'b0, a}, lsb, 1'b1, b);
		repeat (4) @(negedge clk);
		for (int k = 0; k < n; k++) begin
			shift(wd[23 - 8 * k -: 8], lsb, !rd, b);
			rq[23 - 8 * k -: 8] = b;
		end
		drv_en = 1'b0;
		cs_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
endmodule
